// File: logic/sam_delay_sensor.sv
// Sensor with timed drop-out and immediate pick-up
`timescale 1ns/1ps
module sam_delay_sensor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Time base and settings
    input wire logic tick,
    input wire logic [sam_pkg::DLY_W-1:0] dly,
    // Conditions
    input wire logic fault,
    input wire logic good,
    // State
    output logic picked
);
    import sam_pkg::*;

    logic [DLY_W-1:0] count;

    // Delay timer runs only while the fault persists
    always_ff @(posedge clk) begin
        if (rst || !fault || !picked) begin
            count <= '0;
        end else if (tick && count < dly) begin
            count <= count + 1'b1;
        end
    end

    // Drop out on expiry, pick up at once when good
    always_ff @(posedge clk) begin
        if (rst) begin
            picked <= 1'b0;
        end else if (!picked && good) begin
            picked <= 1'b1;
        end else if (picked && fault && (tick || dly == '0) && count + 1'b1 >= dly) begin
            picked <= 1'b0;
        end
    end
endmodule // sam_delay_sensor

// File: logic/sam_source.sv
// Sensor set and availability of one source
`timescale 1ns/1ps
module sam_source (
    // Clock, reset and time base
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    // Settings and measurements
    input wire sam_pkg::sam_cfg_t cfg,
    input wire sam_pkg::sam_meas_t meas,
    input wire logic widen,
    // Results
    output sam_pkg::sam_sense_t sense,
    output logic avail
);
    import sam_pkg::*;

    logic [PROD_W-1:0] uv_pu, uv_do, ov_do, ov_pu, pu_bw, do_bw;
    logic [PROD_W-1:0] f_hi_pu, f_lo_pu, f_hi_do, f_lo_do, v, f;
    logic uv_fault, uv_good, ov_fault, ov_good, f_fault, f_good;
    logic lop_fault;
    logic uv_pk, ov_pk, f_pk, rot_pk, lop_pk;

    // Threshold derivation, widened when asked
    always_comb begin
        v = PROD_W'(meas.volt);
        f = PROD_W'(meas.freq);
        uv_pu = PROD_W'(cfg.nominal) * cfg.uv_pu_pct / PCT_FULL;
        uv_do = uv_pu * cfg.uv_do_pct / PCT_FULL;
        ov_do = PROD_W'(cfg.nominal) * cfg.ov_do_pct / PCT_FULL;
        ov_pu = ov_do * cfg.ov_pu_pct / PCT_FULL;
        pu_bw = PROD_W'(cfg.f_ctr) * cfg.f_pu_bw / PCT_FULL;
        if (widen) begin
            uv_pu = uv_pu * (PCT_FULL - WIDEN_PCT) / PCT_FULL;
            uv_do = uv_do * (PCT_FULL - WIDEN_PCT) / PCT_FULL;
            ov_do = ov_do * (PCT_FULL + WIDEN_PCT) / PCT_FULL;
            ov_pu = ov_pu * (PCT_FULL + WIDEN_PCT) / PCT_FULL;
            pu_bw = pu_bw + PROD_W'(cfg.f_ctr) * WIDEN_PCT / PCT_FULL;
        end
        do_bw = (PROD_W'(cfg.f_ctr) + pu_bw) * cfg.f_do_bw / PCT_FULL;
        f_hi_pu = PROD_W'(cfg.f_ctr) + pu_bw;
        f_lo_pu = PROD_W'(cfg.f_ctr) - pu_bw;
        f_hi_do = f_hi_pu + do_bw;
        f_lo_do = f_lo_pu - (f_lo_pu * cfg.f_do_bw / PCT_FULL);
    end

    // Sensor conditions
    assign uv_fault = v < uv_do;
    assign uv_good = v > uv_pu;
    assign ov_fault = v > ov_do;
    assign ov_good = v < ov_pu;
    assign f_fault = f > f_hi_do || f < f_lo_do;
    assign f_good = f <= f_hi_pu && f >= f_lo_pu;

    // Any angle outside 120 plus or minus 30 degrees
    assign lop_fault = meas.ang12 > ANG_NOM + ANG_TOL ||
        meas.ang12 < ANG_NOM - ANG_TOL ||
        meas.ang23 > ANG_NOM + ANG_TOL ||
        meas.ang23 < ANG_NOM - ANG_TOL ||
        meas.ang31 > ANG_NOM + ANG_TOL ||
        meas.ang31 < ANG_NOM - ANG_TOL;

    // Timed sensors
    sam_delay_sensor u_uv (.clk(clk), .rst(rst), .tick(tick),
        .dly(cfg.uv_dly), .fault(uv_fault), .good(uv_good),
        .picked(uv_pk));
    sam_delay_sensor u_ov (.clk(clk), .rst(rst), .tick(tick),
        .dly(cfg.ov_dly), .fault(ov_fault), .good(ov_good),
        .picked(ov_pk));
    sam_delay_sensor u_f (.clk(clk), .rst(rst), .tick(tick),
        .dly(cfg.f_dly), .fault(f_fault), .good(f_good),
        .picked(f_pk));
    sam_delay_sensor u_lop (.clk(clk), .rst(rst), .tick(tick),
        .dly(cfg.lop_dly), .fault(lop_fault), .good(!lop_fault),
        .picked(lop_pk));

    // Rotation has no delay
    always_ff @(posedge clk) begin
        if (rst) begin
            rot_pk <= 1'b0;
        end else begin
            rot_pk <= meas.rot == cfg.rot_set;
        end
    end

    // Gather sensor states, one driver for the whole struct
    assign sense = '{uv_pk, ov_pk, f_pk, rot_pk, lop_pk};

    // Available when every enabled sensor is picked up
    assign avail = sense.uv && (sense.ov || !cfg.ov_en) &&
        (sense.freq || !cfg.f_en) && (sense.rot || !cfg.rot_en) &&
        (sense.lop || !cfg.lop_en);
endmodule // sam_source

// File: logic/sam_top.sv
// Top of the source availability monitor with APB registers
`timescale 1ns/1ps
module sam_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurements
    input wire sam_pkg::sam_meas_t gen_meas,
    input wire sam_pkg::sam_meas_t utl_meas,
    // Pins, high when open circuit
    input wire logic auto_manual_n,
    input wire logic sync_permit_n,
    // Status
    output logic gen_avail,
    output logic utl_avail,
    output logic sync_active,
    output logic widened
);
    import sam_pkg::*;

    sam_cfg_t cfg [2];
    sam_sense_t sense [2];
    logic avail [2];
    logic [1:0] am_sync, sp_sync;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    sam_sync_t state;
    logic wr, rd_hit;
    logic [31:0] next_rdata;
    // Byte offset of the last word in a settings bank
    localparam logic [7:0] LAST_OFS = 8'({SW_EN, 2'b00});

    // Millisecond tick
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end
    assign tick = tick_cnt == TICK_W'(TICK_CYCLES - 1);

    // Two-stage synchronizers for pins
    always_ff @(posedge clk) begin
        if (rst) begin
            am_sync <= 2'b11;
            sp_sync <= 2'b11;
        end else begin
            am_sync <= {am_sync[0], auto_manual_n};
            sp_sync <= {sp_sync[0], sync_permit_n};
        end
    end

    // One identical sensor set per source
    for (genvar s = 0; s < 2; s++) begin : g_src
        sam_source u_src (
            .clk(clk),
            .rst(rst),
            .tick(tick),
            .cfg(cfg[s]),
            .meas(s == 0 ? gen_meas : utl_meas),
            .widen(s == 0 && sync_active),
            .sense(sense[s]),
            .avail(avail[s])
        );
    end

    assign gen_avail = avail[0];
    assign utl_avail = avail[1];

    // Synchronizer permission
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SAM_IDLE;
        end else if (!(avail[0] && avail[1])) begin
            state <= SAM_IDLE;
        end else if (am_sync[1]) begin
            state <= SAM_AUTO;
        end else if (!sp_sync[1]) begin
            state <= SAM_MANUAL;
        end else begin
            state <= SAM_IDLE;
        end
    end

    assign sync_active = state != SAM_IDLE;
    assign widened = sync_active;

    // APB write strobe, zero wait states
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_hit;

    // Settings registers per source
    for (genvar s = 0; s < 2; s++) begin : g_cfg
        localparam logic [7:0] BASE = s == 0 ? OFS_GEN_BASE : OFS_UTL_BASE;
        logic hit;
        logic [2:0] w;
        logic [7:0] off;
        // Offset into the bank; addresses below the base wrap high
        assign off = paddr - BASE;
        assign hit = off <= LAST_OFS && paddr[1:0] == 2'b00;
        assign w = off[4:2];
        always_ff @(posedge clk) begin
            if (rst) begin
                cfg[s] <= '{RST_NOMINAL, RST_UV_PU, RST_UV_DO, RST_UV_DLY,
                    RST_OV_DO, RST_OV_PU, RST_OV_DLY, RST_F_CTR,
                    RST_F_PU_BW, RST_F_DO_BW, RST_F_DLY, RST_LOP_DLY,
                    1'b0, 1'b0, 1'b0, 1'b0, forward_phase_sequence};
            end else if (wr && hit) begin
                case (w)
                    SW_NOMINAL: cfg[s].nominal <= pwdata[15:0];
                    SW_UV: begin
                        cfg[s].uv_pu_pct <= pwdata[11:0];
                        cfg[s].uv_do_pct <= pwdata[27:16];
                    end
                    SW_OV: begin
                        cfg[s].ov_do_pct <= pwdata[11:0];
                        cfg[s].ov_pu_pct <= pwdata[27:16];
                    end
                    SW_FREQ: begin
                        cfg[s].f_ctr <= pwdata[15:0];
                        cfg[s].f_pu_bw <= pwdata[27:16];
                    end
                    SW_FDLY: begin
                        cfg[s].f_do_bw <= pwdata[11:0];
                        cfg[s].f_dly <= pwdata[31:16];
                    end
                    SW_LOP: begin
                        cfg[s].lop_dly <= pwdata[15:0];
                        cfg[s].uv_dly <= pwdata[31:16];
                    end
                    SW_EN: begin
                        cfg[s].ov_en <= pwdata[0];
                        cfg[s].f_en <= pwdata[1];
                        cfg[s].rot_en <= pwdata[2];
                        cfg[s].lop_en <= pwdata[3];
                        cfg[s].rot_set <= pwdata[4];
                        cfg[s].ov_dly <= pwdata[31:16];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read decode
    always_comb begin
        logic [7:0] gen_off;
        logic [7:0] utl_off;
        logic [2:0] w;
        int s;
        gen_off = paddr - OFS_GEN_BASE;
        utl_off = paddr - OFS_UTL_BASE;
        s = utl_off <= LAST_OFS ? 1 : 0;
        w = s == 1 ? utl_off[4:2] : gen_off[4:2];
        next_rdata = '0;
        rd_hit = 1'b1;
        if (paddr == OFS_CTRL) begin
            next_rdata = {30'h0, !sp_sync[1], !am_sync[1]};
        end else if (paddr == OFS_STATUS) begin
            next_rdata = {16'h0, 1'b0, widened, sync_active, state == SAM_MANUAL,
                sense[1], avail[1], sense[0], avail[0]};
        end else if ((gen_off <= LAST_OFS || utl_off <= LAST_OFS) &&
                paddr[1:0] == 2'b00) begin
            unique case (w)
                SW_NOMINAL: next_rdata = {16'h0, cfg[s].nominal};
                SW_UV: next_rdata = {4'h0, cfg[s].uv_do_pct, 4'h0,
                    cfg[s].uv_pu_pct};
                SW_OV: next_rdata = {4'h0, cfg[s].ov_pu_pct, 4'h0,
                    cfg[s].ov_do_pct};
                SW_FREQ: next_rdata = {4'h0, cfg[s].f_pu_bw, cfg[s].f_ctr};
                SW_FDLY: next_rdata = {cfg[s].f_dly, 4'h0, cfg[s].f_do_bw};
                SW_LOP: next_rdata = {cfg[s].uv_dly, cfg[s].lop_dly};
                SW_EN: next_rdata = {cfg[s].ov_dly, 11'h0, cfg[s].rot_set,
                    cfg[s].lop_en, cfg[s].rot_en, cfg[s].f_en, cfg[s].ov_en};
                default: rd_hit = 1'b0;
            endcase
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end
endmodule // sam_top

// File: shared/sam_pkg.sv
// Package of constants and types for the source availability monitor
package sam_pkg;
    // Clock rate and time base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICK_W = 17;
    localparam int DLY_W = 16;

    // Measurement widths
    localparam int VOLT_W = 16;
    localparam int FREQ_W = 16;
    localparam int ANG_W = 10;
    localparam int PCT_W = 12;
    localparam int PROD_W = 32;

    // Percent scale: settings are in tenths of a percent
    localparam logic [PCT_W-1:0] PCT_FULL = 12'h3e8;

    // Loss of phase limits in whole degrees
    localparam logic [ANG_W-1:0] ANG_NOM = 10'h078;
    localparam logic [ANG_W-1:0] ANG_TOL = 10'h01e;

    // Widening applied to generator thresholds while synchronizing
    localparam logic [PCT_W-1:0] WIDEN_PCT = 12'h032;

    // Phase sequence encodings
    localparam logic forward_phase_sequence = 1'b0;
    localparam logic reverse_phase_sequence = 1'b1;

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_GEN_BASE = 8'h10;
    localparam logic [7:0] OFS_UTL_BASE = 8'h30;
    // Per-source word offsets within a bank
    localparam logic [2:0] SW_NOMINAL = 3'h0;
    localparam logic [2:0] SW_UV = 3'h1;
    localparam logic [2:0] SW_OV = 3'h2;
    localparam logic [2:0] SW_FREQ = 3'h3;
    localparam logic [2:0] SW_FDLY = 3'h4;
    localparam logic [2:0] SW_LOP = 3'h5;
    localparam logic [2:0] SW_EN = 3'h6;

    // Reset values of settings
    localparam logic [VOLT_W-1:0] RST_NOMINAL = 16'h01a0;
    localparam logic [PCT_W-1:0] RST_UV_PU = 12'h384;
    localparam logic [PCT_W-1:0] RST_UV_DO = 12'h384;
    localparam logic [DLY_W-1:0] RST_UV_DLY = 16'h01f4;
    localparam logic [PCT_W-1:0] RST_OV_DO = 12'h44c;
    localparam logic [PCT_W-1:0] RST_OV_PU = 12'h3b6;
    localparam logic [DLY_W-1:0] RST_OV_DLY = 16'h0bb8;
    localparam logic [FREQ_W-1:0] RST_F_CTR = 16'h0258;
    localparam logic [PCT_W-1:0] RST_F_PU_BW = 12'h064;
    localparam logic [PCT_W-1:0] RST_F_DO_BW = 12'h00a;
    localparam logic [DLY_W-1:0] RST_F_DLY = 16'h1388;
    localparam logic [DLY_W-1:0] RST_LOP_DLY = 16'h03e8;

    // Settings of one source
    typedef struct packed {
        logic [VOLT_W-1:0] nominal;
        logic [PCT_W-1:0] uv_pu_pct;
        logic [PCT_W-1:0] uv_do_pct;
        logic [DLY_W-1:0] uv_dly;
        logic [PCT_W-1:0] ov_do_pct;
        logic [PCT_W-1:0] ov_pu_pct;
        logic [DLY_W-1:0] ov_dly;
        logic [FREQ_W-1:0] f_ctr;
        logic [PCT_W-1:0] f_pu_bw;
        logic [PCT_W-1:0] f_do_bw;
        logic [DLY_W-1:0] f_dly;
        logic [DLY_W-1:0] lop_dly;
        logic ov_en;
        logic f_en;
        logic rot_en;
        logic lop_en;
        logic rot_set;
    } sam_cfg_t;

    // Measurements of one source
    typedef struct packed {
        logic [VOLT_W-1:0] volt;
        logic [FREQ_W-1:0] freq;
        logic [ANG_W-1:0] ang12;
        logic [ANG_W-1:0] ang23;
        logic [ANG_W-1:0] ang31;
        logic rot;
    } sam_meas_t;

    // Sensor states of one source
    typedef struct packed {
        logic uv;
        logic ov;
        logic freq;
        logic rot;
        logic lop;
    } sam_sense_t;

    // Synchronizer permission states
    typedef enum logic [1:0] {
        SAM_IDLE = 2'b00,
        SAM_AUTO = 2'b01,
        SAM_MANUAL = 2'b10
    } sam_sync_t;
endpackage

// File: tb/sam_checker.sv
// Port property checker for the source availability monitor
`timescale 1ns/1ps
module sam_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and status
    input wire logic auto_manual_n,
    input wire logic sync_permit_n,
    input wire logic gen_avail,
    input wire logic utl_avail,
    input wire logic sync_active,
    input wire logic widened
);
    import sam_pkg::*;
    logic mapped;
    logic both;
    // Register map decode and joint availability
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h04 ||
        (paddr >= 8'h10 && paddr <= 8'h28) ||
        (paddr >= 8'h30 && paddr <= 8'h48));
    assign both = gen_avail && utl_avail;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_sync_needs_both: assert property (
        sync_active |-> $past(both)) else $error("sync without sources");
    chk_widen_shown: assert property (
        widened == sync_active) else $error("widened flag off");
    chk_auto_starts: assert property (
        (auto_manual_n && both) [*4] |-> sync_active)
        else $error("auto mode did not sync");
    chk_manual_hold: assert property (
        (!auto_manual_n && sync_permit_n) [*4] |-> !sync_active)
        else $error("manual sync without permit");
    chk_permit_starts: assert property (
        (!auto_manual_n && !sync_permit_n && both) [*4] |-> sync_active)
        else $error("permitted sync missing");
    chk_reset_clear: assert property (
        $fell(rst) |-> !gen_avail && !utl_avail && !sync_active)
        else $error("state left over reset");
    chk_status_read: assert property (
        psel && !penable && !pwrite && paddr == OFS_STATUS |=>
        prdata[0] == $past(gen_avail) && prdata[6] == $past(utl_avail)
        && prdata[13] == $past(sync_active)) else $error("status word");
    chk_apb_answer: assert property (
        psel && penable |-> pready && pslverr == !mapped)
        else $error("apb answer wrong");
endmodule // sam_checker

// File: tb/sam_meas_model.sv
// Measurement front end model for both buses
`timescale 1ns/1ps
module sam_meas_model (
    // Commanded generator readings
    input wire logic [15:0] gen_v,
    input wire logic [15:0] gen_f,
    input wire logic [9:0] gen_a,
    input wire logic gen_r,
    // Commanded utility voltage and frequency noise
    input wire logic [15:0] utl_v,
    input wire logic [2:0] jit,
    // Readings to the monitor
    output sam_pkg::sam_meas_t gen_meas,
    output sam_pkg::sam_meas_t utl_meas
);
    import sam_pkg::*;
    // Generator readings as commanded
    assign gen_meas = '{gen_v, gen_f, gen_a, ANG_NOM, ANG_NOM, gen_r};
    // Utility frequency wanders a little around its centre
    assign utl_meas = '{utl_v, 16'h0255 + 16'(jit), ANG_NOM, ANG_NOM,
        ANG_NOM, forward_phase_sequence};
endmodule // sam_meas_model

// File: tb/sam_top_tb.sv
// Self-checking bench for the source availability monitor
`timescale 1ns/1ps
module sam_top_tb;
    import sam_pkg::*;
    typedef struct {logic [4:0] en; int v, f, a, r;} sam_case_t;
    localparam logic [7:0] GEN_EN = OFS_GEN_BASE + 8'h18;
    localparam logic [7:0] UTL_EN = OFS_UTL_BASE + 8'h18;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'hc3db3ba0;
    logic pready, pslverr, er, gen_avail, utl_avail, sync_active, widened;
    logic auto_manual_n = 1, sync_permit_n = 1, gen_r = 0, want, am;
    logic [15:0] gen_v = 416, gen_f = 600, utl_v = 100;
    logic [9:0] gen_a = 120;
    logic [2:0] jit = 0;
    sam_meas_t gen_meas, utl_meas;
    int num_errors = 0;
    int tests_run = 0;
    sam_case_t cases[13] = '{
        '{5'h0f, 416, 600, 120, 0}, '{5'h0f, 374, 600, 120, 0},
        '{5'h0f, 375, 600, 120, 0}, '{5'h0f, 433, 600, 120, 0},
        '{5'h0f, 436, 600, 120, 0}, '{5'h0f, 416, 539, 120, 0},
        '{5'h0f, 416, 541, 120, 0}, '{5'h0f, 416, 661, 120, 0},
        '{5'h0f, 416, 600, 151, 0}, '{5'h0f, 416, 600, 149, 0},
        '{5'h0f, 416, 600, 120, 1}, '{5'h00, 445, 700, 200, 1},
        '{5'h00, 300, 600, 120, 0}};
    // Clock
    always #5 clk = ~clk;
    sam_top sam_top_inst (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_meas(gen_meas), .utl_meas(utl_meas),
        .auto_manual_n(auto_manual_n), .sync_permit_n(sync_permit_n),
        .gen_avail(gen_avail), .utl_avail(utl_avail),
        .sync_active(sync_active), .widened(widened));
    sam_meas_model sam_meas_model_inst (.gen_v(gen_v), .gen_f(gen_f),
        .gen_a(gen_a), .gen_r(gen_r), .utl_v(utl_v), .jit(jit),
        .gen_meas(gen_meas), .utl_meas(utl_meas));
    // Random source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Availability from pick-up conditions; enables ov,f,rot,lop,rotset
    function automatic logic avail_of(sam_case_t c);
        longint n;
        n = RST_NOMINAL;
        return c.v * 1000 > n * RST_UV_PU && (!c.en[0] ||
            c.v * 1000000 < n * RST_OV_DO * RST_OV_PU) && (!c.en[1] ||
            (c.f * 1000 >= RST_F_CTR * (1000 - RST_F_PU_BW) &&
            c.f * 1000 <= RST_F_CTR * (1000 + RST_F_PU_BW))) &&
            (!c.en[3] || (c.a >= 120 - 30 && c.a <= 120 + 30)) &&
            (!c.en[2] || c.r == c.en[4]);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
            input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset();
        apb(0, OFS_GEN_BASE, 0);
        check(rd, 32'(RST_NOMINAL), "nominal reset");
        apb(0, OFS_GEN_BASE + 8'h04, 0);
        check(rd, {4'h0, RST_UV_DO, 4'h0, RST_UV_PU}, "uv reset");
        apb(0, OFS_UTL_BASE + 8'h08, 0);
        check(rd, {4'h0, RST_OV_PU, 4'h0, RST_OV_DO}, "ov reset");
        apb(0, OFS_UTL_BASE + 8'h0c, 0);
        check(rd, {4'h0, RST_F_PU_BW, RST_F_CTR}, "freq reset");
        apb(1, 8'h80, 32'hffffffff);
        apb(0, 8'h80, 0);
        check({rd[30:0], er}, 32'h1, "unmapped read");
        apb(1, GEN_EN, 32'h0bb8001e);
        apb(1, UTL_EN, 32'h0bb80004);
        apb(0, GEN_EN, 0);
        check(rd, 32'h0bb8001e, "gen enables");
        apb(0, UTL_EN, 0);
        check(rd, 32'h0bb80004, "utl enables");
        $display("test registers done");
        // Generator readings around each pick-up boundary except the low angle limit
        foreach (cases[i]) begin
            gen_v <= 16'(cases[i].v);
            gen_f <= 16'(cases[i].f);
            gen_a <= 10'(cases[i].a);
            gen_r <= cases[i].r[0];
            do_reset();
            apb(1, GEN_EN, {27'h0, cases[i].en});
            repeat (4) @(posedge clk);
            check(gen_avail, avail_of(cases[i]), "gen avail");
        end
        $display("test sensors done");
        // Permission from availability and the two pins
        {gen_v, gen_f, gen_a, gen_r} <= {16'd416, 16'd600, 10'd120, 1'b0};
        do_reset();
        apb(1, GEN_EN, 32'h0f);
        apb(1, UTL_EN, 32'h0f);
        for (int i = 0; i < 24; i++) begin
            if (i == 8) utl_v <= 16'd416;
            am = xs() > 32'h7fffffff;
            auto_manual_n <= am;
            sync_permit_n <= xs() > 32'h7fffffff;
            jit <= 3'(xs());
            repeat (6) @(posedge clk);
            want = i >= 8 && (am || !sync_permit_n);
            check(sync_active, want, "sync state");
            check(widened, want, "widened flag");
            apb(0, OFS_STATUS, 0);
            check(rd[14:12], {want, want, want && !am}, "status bits");
            check({rd[6], rd[0]}, {i >= 8, 1'b1}, "avail bits");
        end
        $display("test sync done");
        // Widened limits hold, then a uv drop held by its delay until uv_dly is set to zero, and an immediate pick-up
        auto_manual_n <= 1'b1;
        repeat (6) @(posedge clk);
        gen_v <= 16'd470;
        repeat (6) @(posedge clk);
        check(gen_avail, 1'b1, "widened ov limit");
        check(sync_active, 1'b1, "sync kept");
        gen_v <= 16'd300;
        repeat (6) @(posedge clk);
        check(gen_avail, 1'b1, "uv drop delayed");
        apb(1, OFS_GEN_BASE + 8'h14, 32'h000003e8);
        repeat (4) @(posedge clk);
        check(gen_avail, 1'b0, "uv dropped");
        gen_v <= 16'd416;
        repeat (4) @(posedge clk);
        check(gen_avail, 1'b1, "uv picked up");
        $display("test delays done");
        tally_and_finish();
    end
    // Cut a hang well beyond the roughly 630 cycles of the run
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule // sam_top_tb
bind sam_top sam_checker sam_checker_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auto_manual_n(auto_manual_n), .sync_permit_n(sync_permit_n),
    .gen_avail(gen_avail), .utl_avail(utl_avail),
    .sync_active(sync_active), .widened(widened));
